// ### rtl/fan_setup_pkg.sv
// Purpose: shared constants and types for the fan setup register bank
// Assumes: 25 MHz core clock
// Notes: voltages are counted in 6.25 mV units
package fan_setup_pkg;
    localparam logic [7:0] THRESH_SEL_ADDR = 8'hBE;
    localparam logic [7:0] RAMP_CTRL_ADDR = 8'hBF;
    localparam logic [7:0] BOOST_HYST_ADDR = 8'hC0;
    localparam logic [7:0] THRESH_SEL_RESET = 8'h00;
    localparam logic [7:0] RAMP_CTRL_RESET = 8'h00;
    localparam logic [7:0] BOOST_HYST_RESET = 8'h44;
    localparam int MODE_LSB = 6;
    localparam int REG_HOT_LSB = 0;
    localparam int CPU_HOT_LSB = 4;
    localparam int ZONE1_LSB = 0;
    localparam int ZONE2_LSB = 4;
    localparam int CPU1_THR_BIT = 0;
    localparam int CPU2_THR_BIT = 1;
    localparam int IN8_THR_BIT = 2;
    localparam int IN9_THR_BIT = 3;
    localparam int GPIO_THR_LSB = 4;
    localparam int CLK_HZ = 25_000_000;
    localparam int RAMP_UNIT_MS = 50;
    localparam int RAMP_UNIT_CYCLES = RAMP_UNIT_MS * (CLK_HZ / 1000);
    localparam int TICK_W = 21;
    localparam logic [8:0] VOLT_TOP = 9'h100;
    localparam logic [8:0] VOLT_FLOOR_M00 = 9'h086;
    localparam logic [8:0] VOLT_FLOOR_M01 = 9'h085;
    localparam logic [8:0] VOLT_FLOOR_M11 = 9'h006;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_OFF = 8'h00;

    typedef enum logic [1:0] {
        CODE_6BIT_COARSE = 2'h0,
        CODE_7BIT_FINE = 2'h1,
        CODE_7BIT_LOW = 2'h2,
        CODE_7BIT_HIGH = 2'h3
    } voltage_code_mode_t;

    typedef struct packed {
        logic [7:0] input_threshold_select;
        logic [7:0] pwm_ramp_delay_control;
        logic [7:0] boost_hysteresis_zones_1_2;
    } regs_t;
endpackage

// ### rtl/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to i_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
module pin_sync (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.stage = {cur.stage[1:0], i_pin};
        if (cur.stage[1] == cur.stage[2]) begin
            next_cur.level = cur.stage[2];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_level = cur.level;
endmodule

// ### rtl/fan_setup_ramp_boost_regs.sv
// Purpose: setup registers for voltage codes, thresholds, hot ramping, boost
// Assumes: register port driven by the serial management core on i_clk
// Notes: duty and voltage outputs are registered
// Behaviour
// - voltage-code mode from control-2 bits 7:6
// - mode 00: six bits, 12.5mV steps
// - mode 01: seven bits, 6.25mV steps
// - mode 10: bits 6:0, bit7 zero
// - mode 11: bits 7:1, bit0 zero
// - bits 0/1 select cpu low thresholds
// - input 8/9 thresholds only in mode 00
// - bits 4-7 select gpio low thresholds
// - regulator delay 3:0, cpu delay 7:4
// - delay n times 50ms; zero jumps full
// - zone hysteresis nibbles, reset 44h
// - boost holds until below hysteresis
`timescale 1ns/100ps
module fan_setup_ramp_boost_regs #(
    parameter int RAMP_UNIT = fan_setup_pkg::RAMP_UNIT_CYCLES,
    parameter logic [7:0] RAMP_STEP = 8'h10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] i_func_ctrl2,
    input wire logic [7:0] i_cpu1_code,
    input wire logic [7:0] i_cpu2_code,
    input wire logic i_regulator_hot_input,
    input wire logic i_cpu_hot_input,
    input wire logic [7:0] i_zone1_temp,
    input wire logic [7:0] i_zone2_temp,
    input wire logic [7:0] i_zone1_boost_temp,
    input wire logic [7:0] i_zone2_boost_temp,
    output logic [7:0] o_reg_rdata,
    output logic [8:0] o_cpu1_voltage,
    output logic [8:0] o_cpu2_voltage,
    output logic o_cpu1_code_low_threshold,
    output logic o_cpu2_code_low_threshold,
    output logic o_input8_low_threshold,
    output logic o_input9_low_threshold,
    output logic [3:0] o_gpio_low_threshold,
    output logic [7:0] o_regulator_hot_duty,
    output logic [7:0] o_cpu_hot_duty,
    output logic [1:0] o_boost_zone
);
    // refuse settings the tick counter or the stepper cannot serve
    if (RAMP_UNIT < 1 || RAMP_UNIT >= (1 << fan_setup_pkg::TICK_W)) begin : g_bad_unit
        $error("RAMP_UNIT out of range");
    end
    if (RAMP_STEP == 8'h00) begin : g_bad_step
        $error("RAMP_STEP must be nonzero");
    end

    typedef struct packed {
        fan_setup_pkg::regs_t regs;
        logic [7:0] rdata;
        logic [fan_setup_pkg::TICK_W-1:0] tick_cnt;
        logic [1:0][3:0] ramp_cnt;
        logic [1:0][7:0] duty;
        logic [1:0] boost;
        logic [1:0][8:0] volt;
        logic [7:0] thr;
    } top_state_t;

    top_state_t cur;
    top_state_t next_cur;
    logic [1:0] hot;
    logic [1:0][7:0] code_in;
    logic [1:0][7:0] temp_in;
    logic [1:0][7:0] boost_temp_in;

    // code to voltage, highest code gives lowest voltage
    function automatic logic [8:0] code_to_volt(input logic [1:0] mode, input logic [7:0] code);
        logic [8:0] drop;
        logic [8:0] floor_v;
        drop = 9'h000;
        floor_v = fan_setup_pkg::VOLT_FLOOR_M01;
        case (fan_setup_pkg::voltage_code_mode_t'(mode))
            fan_setup_pkg::CODE_6BIT_COARSE: begin
                drop = {2'h0, code[5:0], 1'b0};
                floor_v = fan_setup_pkg::VOLT_FLOOR_M00;
            end
            fan_setup_pkg::CODE_7BIT_FINE: begin
                drop = {2'h0, code[6:0]};
            end
            fan_setup_pkg::CODE_7BIT_LOW: begin
                drop = {2'h0, code[6:0]};
            end
            fan_setup_pkg::CODE_7BIT_HIGH: begin
                drop = {1'b0, code[7:1], 1'b0};
                floor_v = fan_setup_pkg::VOLT_FLOOR_M11;
            end
            default: begin
                drop = 9'h000;
            end
        endcase
        // unused codes past the range saturate at the floor
        if (fan_setup_pkg::VOLT_TOP - drop < floor_v || drop > fan_setup_pkg::VOLT_TOP) begin
            return floor_v;
        end
        return fan_setup_pkg::VOLT_TOP - drop;
    endfunction

    pin_sync u_sync_reg_hot (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_pin(i_regulator_hot_input),
        .o_level(hot[0])
    );

    pin_sync u_sync_cpu_hot (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_pin(i_cpu_hot_input),
        .o_level(hot[1])
    );

    assign code_in = {i_cpu2_code, i_cpu1_code};
    assign temp_in = {i_zone2_temp, i_zone1_temp};
    assign boost_temp_in = {i_zone2_boost_temp, i_zone1_boost_temp};

    always_comb begin
        logic [1:0] mode;
        logic [1:0][3:0] delay;
        logic [1:0][3:0] hyst;
        logic tick;
        logic [8:0] up_sum;
        logic [9:0] low_sum;
        mode = 2'h0;
        delay = '0;
        hyst = '0;
        tick = 1'b0;
        up_sum = 9'h000;
        low_sum = 10'h000;
        next_cur = cur;

        if (i_reg_wr) begin
            case (i_reg_addr)
                fan_setup_pkg::THRESH_SEL_ADDR: begin
                    next_cur.regs.input_threshold_select = i_reg_wdata;
                end
                fan_setup_pkg::RAMP_CTRL_ADDR: begin
                    next_cur.regs.pwm_ramp_delay_control = i_reg_wdata;
                end
                fan_setup_pkg::BOOST_HYST_ADDR: begin
                    next_cur.regs.boost_hysteresis_zones_1_2 = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                fan_setup_pkg::THRESH_SEL_ADDR: begin
                    next_cur.rdata = cur.regs.input_threshold_select;
                end
                fan_setup_pkg::RAMP_CTRL_ADDR: begin
                    next_cur.rdata = cur.regs.pwm_ramp_delay_control;
                end
                fan_setup_pkg::BOOST_HYST_ADDR: begin
                    next_cur.rdata = cur.regs.boost_hysteresis_zones_1_2;
                end
                default: begin
                    next_cur.rdata = 8'h00;
                end
            endcase
        end

        mode = i_func_ctrl2[fan_setup_pkg::MODE_LSB +: 2];
        for (int p = 0; p < 2; p++) begin
            next_cur.volt[p] = code_to_volt(mode, code_in[p]);
        end

        next_cur.thr[0] = cur.regs.input_threshold_select[fan_setup_pkg::CPU1_THR_BIT];
        next_cur.thr[1] = cur.regs.input_threshold_select[fan_setup_pkg::CPU2_THR_BIT];
        next_cur.thr[2] = cur.regs.input_threshold_select[fan_setup_pkg::IN8_THR_BIT]
            && mode == fan_setup_pkg::CODE_6BIT_COARSE;
        next_cur.thr[3] = cur.regs.input_threshold_select[fan_setup_pkg::IN9_THR_BIT]
            && mode == fan_setup_pkg::CODE_6BIT_COARSE;
        next_cur.thr[7:4] = cur.regs.input_threshold_select[fan_setup_pkg::GPIO_THR_LSB +: 4];

        delay[0] = cur.regs.pwm_ramp_delay_control[fan_setup_pkg::REG_HOT_LSB +: 4];
        delay[1] = cur.regs.pwm_ramp_delay_control[fan_setup_pkg::CPU_HOT_LSB +: 4];

        if (cur.tick_cnt == fan_setup_pkg::TICK_W'(RAMP_UNIT - 1)) begin
            tick = 1'b1;
            next_cur.tick_cnt = '0;
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 1'b1;
        end

        for (int c = 0; c < 2; c++) begin
            if (delay[c] == 4'h0) begin
                next_cur.duty[c] = hot[c] ? fan_setup_pkg::DUTY_FULL : fan_setup_pkg::DUTY_OFF;
                next_cur.ramp_cnt[c] = 4'h0;
            end else if (tick) begin
                if (cur.ramp_cnt[c] + 4'h1 >= delay[c]) begin
                    next_cur.ramp_cnt[c] = 4'h0;
                    if (hot[c]) begin
                        up_sum = {1'b0, cur.duty[c]} + {1'b0, RAMP_STEP};
                        next_cur.duty[c] = up_sum[8] ? fan_setup_pkg::DUTY_FULL : up_sum[7:0];
                    end else if (cur.duty[c] > RAMP_STEP) begin
                        next_cur.duty[c] = cur.duty[c] - RAMP_STEP;
                    end else begin
                        next_cur.duty[c] = fan_setup_pkg::DUTY_OFF;
                    end
                end else begin
                    next_cur.ramp_cnt[c] = cur.ramp_cnt[c] + 4'h1;
                end
            end
        end

        hyst[0] = cur.regs.boost_hysteresis_zones_1_2[fan_setup_pkg::ZONE1_LSB +: 4];
        hyst[1] = cur.regs.boost_hysteresis_zones_1_2[fan_setup_pkg::ZONE2_LSB +: 4];
        for (int z = 0; z < 2; z++) begin
            low_sum = {2'h0, temp_in[z]} + {6'h00, hyst[z]};
            if (temp_in[z] > boost_temp_in[z]) begin
                next_cur.boost[z] = 1'b1;
            end else if (low_sum < {2'h0, boost_temp_in[z]}) begin
                next_cur.boost[z] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cur <= '0;
            cur.regs.input_threshold_select <= fan_setup_pkg::THRESH_SEL_RESET;
            cur.regs.pwm_ramp_delay_control <= fan_setup_pkg::RAMP_CTRL_RESET;
            cur.regs.boost_hysteresis_zones_1_2 <= fan_setup_pkg::BOOST_HYST_RESET;
            cur.volt <= {fan_setup_pkg::VOLT_TOP, fan_setup_pkg::VOLT_TOP};
        end else begin
            cur <= next_cur;
        end
    end

    assign o_reg_rdata = cur.rdata;
    assign o_cpu1_voltage = cur.volt[0];
    assign o_cpu2_voltage = cur.volt[1];
    assign o_cpu1_code_low_threshold = cur.thr[0];
    assign o_cpu2_code_low_threshold = cur.thr[1];
    assign o_input8_low_threshold = cur.thr[2];
    assign o_input9_low_threshold = cur.thr[3];
    assign o_gpio_low_threshold = cur.thr[7:4];
    assign o_regulator_hot_duty = cur.duty[0];
    assign o_cpu_hot_duty = cur.duty[1];
    assign o_boost_zone = cur.boost;
endmodule

// ### verif/fan_setup_ramp_boost_regs_checker.sv
// Purpose: port assertions for the fan setup register bank
// Assumes: bound into fan_setup_ramp_boost_regs
// Notes: shadow registers follow the write strobe
`timescale 1ns/100ps
module fan_setup_ramp_boost_regs_checker (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] i_func_ctrl2,
    input wire logic [7:0] i_cpu1_code,
    input wire logic i_regulator_hot_input,
    input wire logic i_cpu_hot_input,
    input wire logic [7:0] i_zone1_temp,
    input wire logic [7:0] i_zone2_temp,
    input wire logic [7:0] i_zone1_boost_temp,
    input wire logic [7:0] i_zone2_boost_temp,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [8:0] o_cpu1_voltage,
    input wire logic o_cpu1_code_low_threshold,
    input wire logic o_input8_low_threshold,
    input wire logic [3:0] o_gpio_low_threshold,
    input wire logic [7:0] o_regulator_hot_duty,
    input wire logic [7:0] o_cpu_hot_duty,
    input wire logic [1:0] o_boost_zone
);
    fan_setup_pkg::regs_t sh;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sh <= {16'h0000, 8'h44};
        end else if (i_reg_wr) begin
            if (i_reg_addr == 8'hBE) sh.input_threshold_select <= i_reg_wdata;
            if (i_reg_addr == 8'hBF) sh.pwm_ramp_delay_control <= i_reg_wdata;
            if (i_reg_addr == 8'hC0) sh.boost_hysteresis_zones_1_2 <= i_reg_wdata;
        end
    end
    // saturating decode, higher code means lower voltage
    function automatic logic [8:0] volt(input logic [1:0] m, input logic [7:0] c);
        logic [8:0] d;
        logic [8:0] f;
        d = (m == 2'h0) ? {2'h0, c[5:0], 1'h0} :
            (m == 2'h3) ? {1'h0, c[7:1], 1'h0} : {2'h0, c[6:0]};
        f = (m == 2'h0) ? 9'h086 : (m == 2'h3) ? 9'h006 : 9'h085;
        return (9'h100 - d < f) ? f : 9'h100 - d;
    endfunction
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_m0;
        i_func_ctrl2[7:6] == 2'h0 |=> o_cpu1_voltage == volt(2'h0, $past(i_cpu1_code));
    endproperty
    a_m0: assert property (p_m0) else $error("mode 0 voltage wrong");
    property p_m1;
        i_func_ctrl2[7:6] == 2'h1 |=> o_cpu1_voltage == volt(2'h1, $past(i_cpu1_code));
    endproperty
    a_m1: assert property (p_m1) else $error("mode 1 voltage wrong");
    property p_m2;
        i_func_ctrl2[7:6] == 2'h2 |=> o_cpu1_voltage == volt(2'h2, $past(i_cpu1_code));
    endproperty
    a_m2: assert property (p_m2) else $error("mode 2 voltage wrong");
    property p_m3;
        i_func_ctrl2[7:6] == 2'h3 |=> o_cpu1_voltage == volt(2'h3, $past(i_cpu1_code));
    endproperty
    a_m3: assert property (p_m3) else $error("mode 3 voltage wrong");
    property p_rd_ramp;
        i_reg_rd && !i_reg_wr && i_reg_addr == 8'hBF |=>
            o_reg_rdata == $past(sh.pwm_ramp_delay_control);
    endproperty
    a_rd_ramp: assert property (p_rd_ramp) else $error("ramp read wrong");
    property p_thr;
        o_cpu1_code_low_threshold == $past(sh.input_threshold_select[0]) &&
            o_gpio_low_threshold == $past(sh.input_threshold_select[7:4]);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold select wrong");
    property p_in8;
        o_input8_low_threshold ==
            ($past(sh.input_threshold_select[2]) && $past(i_func_ctrl2[7:6]) == 2'h0);
    endproperty
    a_in8: assert property (p_in8) else $error("input 8 select wrong");
    property p_reg_fast;
        i_regulator_hot_input [*6] ##0 sh.pwm_ramp_delay_control[3:0] == 4'h0 |=>
            o_regulator_hot_duty == 8'hFF;
    endproperty
    a_reg_fast: assert property (p_reg_fast) else $error("no jump to full");
    property p_cpu_off;
        !i_cpu_hot_input [*6] ##0 sh.pwm_ramp_delay_control[7:4] == 4'h0 |=>
            o_cpu_hot_duty == 8'h00;
    endproperty
    a_cpu_off: assert property (p_cpu_off) else $error("cpu duty not off");
    property p_set;
        i_zone1_temp > i_zone1_boost_temp |=> o_boost_zone[0];
    endproperty
    a_set: assert property (p_set) else $error("boost not set");
    property p_hold;
        o_boost_zone[1] && {1'h0, i_zone2_temp} + sh.boost_hysteresis_zones_1_2[7:4] >=
            {1'h0, i_zone2_boost_temp} |=> o_boost_zone[1];
    endproperty
    a_hold: assert property (p_hold) else $error("boost released early");
    property p_clr;
        {1'h0, i_zone1_temp} + sh.boost_hysteresis_zones_1_2[3:0] < {1'h0, i_zone1_boost_temp}
            |=> !o_boost_zone[0];
    endproperty
    a_clr: assert property (p_clr) else $error("boost not cleared");
    c_boost: cover property (o_boost_zone == 2'h1);
    c_full: cover property (o_regulator_hot_duty == 8'hFF);
    c_m3: cover property (i_func_ctrl2[7:6] == 2'h3);
endmodule

// ### verif/fan_setup_ramp_boost_regs_bench.sv
// Purpose: directed bench for the fan setup register bank
// Assumes: ramp unit shortened to 10 cycles
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module fan_setup_ramp_boost_regs_bench;
    localparam int UNIT = 10;
    logic i_clk = 1'h0, i_nrst = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
    logic i_regulator_hot_input = 1'h0, i_cpu_hot_input = 1'h0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_func_ctrl2 = 8'h00;
    logic [7:0] i_cpu1_code = 8'h00, i_cpu2_code = 8'h00;
    logic [7:0] i_zone1_temp = 8'h00, i_zone2_temp = 8'h00;
    logic [7:0] i_zone1_boost_temp = 8'h32, i_zone2_boost_temp = 8'h32;
    logic [7:0] o_reg_rdata, o_regulator_hot_duty, o_cpu_hot_duty;
    logic [8:0] o_cpu1_voltage, o_cpu2_voltage;
    logic o_cpu1_code_low_threshold, o_cpu2_code_low_threshold;
    logic o_input8_low_threshold, o_input9_low_threshold;
    logic [3:0] o_gpio_low_threshold;
    logic [1:0] o_boost_zone;
    int err_total = 0;
    int tests_run = 0;
    logic [1:0] vm [10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [7:0] vc [10] = '{8'h00, 8'hC5, 8'hFF, 8'h7F, 8'h90, 8'h83, 8'hFF, 8'h01, 8'hFF, 8'h20};
    logic [8:0] vv [10] = '{9'h100, 9'h0F6, 9'h086, 9'h085, 9'h0F0, 9'h0FD, 9'h085, 9'h100,
        9'h006, 9'h0E0};
    logic [7:0] bt [5] = '{8'h32, 8'h33, 8'h32, 8'h2F, 8'h2E};
    logic [1:0] bz [5] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h0};
    always #20 i_clk = ~i_clk;
    fan_setup_ramp_boost_regs #(.RAMP_UNIT(UNIT), .RAMP_STEP(8'h10))
        fan_setup_ramp_boost_regs_i (.*);
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one idle cycle after each strobe keeps drives apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'h1;
        cyc(1);
        i_reg_wr = 1'h0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_addr = a;
        i_reg_rd = 1'h1;
        cyc(1);
        i_reg_rd = 1'h0;
        chk(o_reg_rdata, e);
        cyc(1);
    endtask
    function automatic logic [7:0] thr();
        return {o_gpio_low_threshold, o_input9_low_threshold, o_input8_low_threshold,
            o_cpu2_code_low_threshold, o_cpu1_code_low_threshold};
    endfunction
    function automatic logic [7:0] duty(input logic s);
        return s ? o_cpu_hot_duty : o_regulator_hot_duty;
    endfunction
    task automatic tick(inout int c);
        cyc(1);
        c++;
        if (c > 400) begin
            chk(c, 0);
            report_and_stop();
        end
    endtask
    // tick phase is free running, so time the second step
    task automatic gap(input logic s, input int n, input logic [7:0] d);
        logic [7:0] a;
        logic [7:0] e;
        int c;
        c = 0;
        a = duty(s);
        while (duty(s) === a) tick(c);
        a = duty(s);
        c = 0;
        while (duty(s) === a) tick(c);
        // eight-bit sum, so adding F0h wraps to a 10h down step; the duty itself clamps at 00h
        e = a + d;
        chk(c, n * UNIT);
        chk(duty(s), e);
    endtask
    initial begin
        cyc(16);
        i_nrst = 1'h1;
        rd(8'hBE, 8'h00);
        rd(8'hBF, 8'h00);
        rd(8'hC0, 8'h44);
        wr(8'hC1, 8'hFF);
        rd(8'hC1, 8'h00);
        wr(8'hBF, 8'h5C);
        rd(8'hBF, 8'h5C);
        for (int k = 0; k < 10; k++) begin
            i_func_ctrl2 = {vm[k], 6'h00};
            i_cpu1_code = vc[k];
            i_cpu2_code = vc[k];
            cyc(2);
            chk(o_cpu1_voltage, vv[k]);
            chk(o_cpu2_voltage, vv[k]);
        end
        wr(8'hBE, 8'hA7);
        i_func_ctrl2 = 8'h40;
        cyc(2);
        chk(thr(), 8'hA3);
        i_func_ctrl2 = 8'h00;
        cyc(2);
        chk(thr(), 8'hA7);
        wr(8'hBE, 8'h5A);
        chk(thr(), 8'h5A);
        wr(8'hBF, 8'h00);
        i_regulator_hot_input = 1'h1;
        i_cpu_hot_input = 1'h1;
        cyc(8);
        chk({o_cpu_hot_duty, o_regulator_hot_duty}, 16'hFFFF);
        i_regulator_hot_input = 1'h0;
        i_cpu_hot_input = 1'h0;
        cyc(8);
        chk({o_cpu_hot_duty, o_regulator_hot_duty}, 16'h0000);
        wr(8'hBF, 8'hF1);
        i_regulator_hot_input = 1'h1;
        i_cpu_hot_input = 1'h1;
        gap(1'h0, 1, 8'h10);
        gap(1'h1, 15, 8'h10);
        cyc(2600);
        chk({o_cpu_hot_duty, o_regulator_hot_duty}, 16'hFFFF);
        i_regulator_hot_input = 1'h0;
        i_cpu_hot_input = 1'h0;
        gap(1'h0, 1, 8'hF0);
        gap(1'h1, 15, 8'hF0);
        cyc(2600);
        chk({o_cpu_hot_duty, o_regulator_hot_duty}, 16'h0000);
        wr(8'hC0, 8'h23);
        for (int k = 0; k < 5; k++) begin
            i_zone1_temp = bt[k];
            i_zone2_temp = bt[k];
            cyc(2);
            chk(o_boost_zone, bz[k]);
        end
        report_and_stop();
    end
endmodule
bind fan_setup_ramp_boost_regs fan_setup_ramp_boost_regs_checker
    fan_setup_ramp_boost_regs_checker_i (.*);
